// *** logic/rx_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Accept a change only once two stages agree
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
    if (!aresetn) begin
      d = 4'hf;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  assign level = q.lvl;
endmodule : rx_pin_sync
`default_nettype wire

// *** logic/uart_seq_ctrl.sv ***
// Behaviour
// RQ1: Software clears transmit and receive enables before clearing power.
// RQ2: Software sets power first, then transmit or receive enable.
// RQ3: Byte sent raises completion interrupt; writes while sending are ignored.
// RQ4: Error flags clear on status read followed by receive buffer read.
// RQ5: Frame arriving with error pending flags overrun; status stays set.
// RQ6: Receiver checks only one stop bit, ignores any second.
// RQ7: Inversion option inverts transmit line only, never receive.
// RQ8: Logic keeps running normally whenever its clock runs.
// RQ9: Without clock all registers and transmit pin hold their value.
// RQ10: After clock resumes software rewrites power and enables to zero.
// RQ11: Both sides keep baud error within the partner's tolerance.
// RQ12: Power, transmit enable, receive enable sit at mode bits 7, 6, 5.
// RQ13: On overrun the new byte is discarded, buffer unchanged.
`timescale 1ns/1ps
`default_nettype none
module uart_seq_ctrl #(
  parameter int ADDR_W = 8,
  parameter int BAUD_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic irq
);
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    uart_seq_pkg::op_mode_t mode;
    logic [BAUD_W-1:0] baud_div;
    uart_seq_pkg::irq_t irq_stat;
    uart_seq_pkg::irq_t irq_mask;
    logic irq;
    uart_seq_pkg::tx_state_t tx_st;
    logic [BAUD_W-1:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_data;
    logic serial_out;
    uart_seq_pkg::rx_state_t rx_st;
    logic [BAUD_W-1:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] rx_buf;
    logic rx_full;
    uart_seq_pkg::rx_err_t rx_err;
    logic err_armed;
  } state_t;
  state_t q;
  state_t d;
  logic rx_lvl;
  logic wr_fire;
  logic rd_fire;
  logic tx_on;
  logic rx_on;
  logic rx_done_ev;
  logic [31:0] merged;
  function automatic logic is_reg(logic [ADDR_W-1:0] a, logic [7:0] ofs);
    return a[ADDR_W-1:2] == (ADDR_W-2)'(ofs >> 2);
  endfunction : is_reg
  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return is_reg(a, uart_seq_pkg::OFS_OP_MODE) || is_reg(a, uart_seq_pkg::OFS_BAUD) ||
           is_reg(a, uart_seq_pkg::OFS_TX) || is_reg(a, uart_seq_pkg::OFS_RXBUF) ||
           is_reg(a, uart_seq_pkg::OFS_RXERR) || is_reg(a, uart_seq_pkg::OFS_IRQ_STAT) ||
           is_reg(a, uart_seq_pkg::OFS_IRQ_MASK);
  endfunction : mapped
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  function automatic state_t reset_state();
    state_t s;
    s = '0;
    s.mode = uart_seq_pkg::op_mode_t'(uart_seq_pkg::OP_MODE_RST);
    s.baud_div = BAUD_W'(uart_seq_pkg::BAUD_DIV_RST);
    s.irq_mask = uart_seq_pkg::irq_t'(uart_seq_pkg::IRQ_MASK_RST);
    s.tx_st = uart_seq_pkg::TX_IDLE;
    s.rx_st = uart_seq_pkg::RX_IDLE;
    s.serial_out = 1'b1;
    return s;
  endfunction : reset_state
  rx_pin_sync u_rx_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(serial_in_pin),
    .level(rx_lvl)
  );
  assign wr_fire = q.aw_got & q.w_got & ~q.bvalid;
  assign rd_fire = q.arready & arvalid;
  assign tx_on = q.mode.power & q.mode.tx_en;
  assign rx_on = q.mode.power & q.mode.rx_en;
  assign rx_done_ev = rx_on && q.rx_st == uart_seq_pkg::RX_STOP && q.rx_cnt == '0;
  always_comb begin
    d = q;
    merged = '0;
    if (q.awready && awvalid) begin
      d.aw_got = 1'b1;
      d.aw_addr = awaddr;
    end
    if (q.wready && wvalid) begin
      d.w_got = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.aw_addr) ? uart_seq_pkg::RESP_OKAY : uart_seq_pkg::RESP_SLVERR;
      if (is_reg(q.aw_addr, uart_seq_pkg::OFS_OP_MODE)) begin
        merged = merge({24'h00_0000, q.mode}, q.wdata, q.wstrb);
        d.mode = uart_seq_pkg::op_mode_t'(merged[7:0]); // RQ12
        d.mode.rsvd = '0;
      end
      if (is_reg(q.aw_addr, uart_seq_pkg::OFS_BAUD)) begin
        merged = merge(32'(q.baud_div), q.wdata, q.wstrb);
        d.baud_div = merged[BAUD_W-1:0];
      end
      if (is_reg(q.aw_addr, uart_seq_pkg::OFS_IRQ_MASK)) begin
        merged = merge({29'h0, q.irq_mask}, q.wdata, q.wstrb);
        d.irq_mask = uart_seq_pkg::irq_t'(merged[2:0]);
      end
      if (is_reg(q.aw_addr, uart_seq_pkg::OFS_TX) && q.wstrb[0] && tx_on &&
          q.tx_st == uart_seq_pkg::TX_IDLE) begin // RQ3
        d.tx_data = q.wdata[7:0];
        d.tx_st = uart_seq_pkg::TX_START;
        d.tx_cnt = q.baud_div - 1'b1;
      end
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rresp = mapped(araddr) ? uart_seq_pkg::RESP_OKAY : uart_seq_pkg::RESP_SLVERR;
      d.rdata = '0;
      if (is_reg(araddr, uart_seq_pkg::OFS_OP_MODE)) begin
        d.rdata = {24'h00_0000, q.mode};
      end
      if (is_reg(araddr, uart_seq_pkg::OFS_BAUD)) begin
        d.rdata = 32'(q.baud_div);
      end
      if (is_reg(araddr, uart_seq_pkg::OFS_TX)) begin
        d.rdata = uart_seq_pkg::TX_IDLE_WORD | 32'(q.tx_st != uart_seq_pkg::TX_IDLE);
      end
      if (is_reg(araddr, uart_seq_pkg::OFS_RXERR)) begin
        d.rdata = {30'h0, q.rx_err};
        if (q.rx_err != '0) begin
          d.err_armed = 1'b1; // RQ4
        end
      end
      if (is_reg(araddr, uart_seq_pkg::OFS_RXBUF)) begin
        d.rdata = {24'h00_0000, q.rx_buf};
        d.rx_full = 1'b0;
        if (q.err_armed) begin
          d.rx_err = '0; // RQ4
          d.err_armed = 1'b0;
        end
      end
      if (is_reg(araddr, uart_seq_pkg::OFS_IRQ_STAT)) begin
        d.rdata = {29'h0, q.irq_stat};
        d.irq_stat = '0;
      end
      if (is_reg(araddr, uart_seq_pkg::OFS_IRQ_MASK)) begin
        d.rdata = {29'h0, q.irq_mask};
      end
    end
    if (!tx_on) begin
      d.tx_st = uart_seq_pkg::TX_IDLE; // RQ1
    end else if (q.tx_st != uart_seq_pkg::TX_IDLE) begin
      if (q.tx_cnt != '0) begin
        d.tx_cnt = q.tx_cnt - 1'b1;
      end else begin
        d.tx_cnt = q.baud_div - 1'b1;
        case (q.tx_st)
          uart_seq_pkg::TX_START: begin
            d.tx_st = uart_seq_pkg::TX_DATA;
            d.tx_bit = '0;
          end
          uart_seq_pkg::TX_DATA: begin
            d.tx_data = {1'b0, q.tx_data[7:1]};
            d.tx_bit = q.tx_bit + 1'b1;
            if (q.tx_bit == 3'h7) begin
              d.tx_st = uart_seq_pkg::TX_STOP1;
            end
          end
          uart_seq_pkg::TX_STOP1: begin
            if (q.mode.tx_stop2) begin
              d.tx_st = uart_seq_pkg::TX_STOP2;
            end else begin
              d.tx_st = uart_seq_pkg::TX_IDLE;
              d.irq_stat.tx = 1'b1; // RQ3
            end
          end
          uart_seq_pkg::TX_STOP2: begin
            d.tx_st = uart_seq_pkg::TX_IDLE;
            d.irq_stat.tx = 1'b1; // RQ3
          end
          default: begin
            d.tx_st = uart_seq_pkg::TX_IDLE;
          end
        endcase
      end
    end
    // Line level from next state; pin holds while clock stands
    case (d.tx_st)
      uart_seq_pkg::TX_START: d.serial_out = 1'b0 ^ d.mode.tx_inv; // RQ7
      uart_seq_pkg::TX_DATA: d.serial_out = d.tx_data[0] ^ d.mode.tx_inv; // RQ7
      default: d.serial_out = 1'b1 ^ d.mode.tx_inv; // RQ9
    endcase
    // Receiver on the synchronised, never inverted line
    if (!rx_on) begin
      d.rx_st = uart_seq_pkg::RX_IDLE; // RQ1
    end else begin
      case (q.rx_st)
        uart_seq_pkg::RX_IDLE: begin
          if (!rx_lvl) begin
            d.rx_st = uart_seq_pkg::RX_START;
            d.rx_cnt = q.baud_div >> 1;
          end
        end
        uart_seq_pkg::RX_START: begin
          if (q.rx_cnt != '0) begin
            d.rx_cnt = q.rx_cnt - 1'b1;
          end else if (rx_lvl) begin
            d.rx_st = uart_seq_pkg::RX_IDLE;
          end else begin
            d.rx_st = uart_seq_pkg::RX_DATA;
            d.rx_cnt = q.baud_div - 1'b1;
            d.rx_bit = '0;
          end
        end
        uart_seq_pkg::RX_DATA: begin
          if (q.rx_cnt != '0) begin
            d.rx_cnt = q.rx_cnt - 1'b1;
          end else begin
            d.rx_cnt = q.baud_div - 1'b1;
            d.rx_shift = {rx_lvl, q.rx_shift[7:1]};
            d.rx_bit = q.rx_bit + 1'b1;
            if (q.rx_bit == 3'h7) begin
              d.rx_st = uart_seq_pkg::RX_STOP;
            end
          end
        end
        uart_seq_pkg::RX_STOP: begin
          if (q.rx_cnt != '0) begin
            d.rx_cnt = q.rx_cnt - 1'b1;
          end else begin
            d.rx_st = uart_seq_pkg::RX_IDLE; // RQ6
            if (d.rx_full || d.rx_err != '0) begin
              d.rx_err.overrun = 1'b1; // RQ5
              d.irq_stat.err = 1'b1;
            end else begin
              d.rx_buf = q.rx_shift; // RQ13
              d.rx_full = 1'b1;
              d.irq_stat.rx = 1'b1;
              if (!rx_lvl) begin
                d.rx_err.frame = 1'b1;
                d.irq_stat.err = 1'b1;
              end
            end
          end
        end
        default: begin
          d.rx_st = uart_seq_pkg::RX_IDLE;
        end
      endcase
    end
    d.irq = |(d.irq_stat & d.irq_mask);
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready = ~d.w_got & ~d.bvalid;
    d.arready = ~d.rvalid;
    if (!aresetn) begin
      d = reset_state();
    end
  end
  always_ff @(posedge aclk) begin
    q <= d; // RQ8
  end
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign serial_out_pin = q.serial_out;
  assign irq = q.irq;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence err_stat_read;
    rd_fire && is_reg(araddr, uart_seq_pkg::OFS_RXERR) && q.rx_err != '0;
  endsequence
  sequence buf_read;
    rd_fire && is_reg(araddr, uart_seq_pkg::OFS_RXBUF) && !rx_done_ev;
  endsequence
  AST_TX_DONE_IRQ: assert property ( // RQ3
    (tx_on && q.tx_st == uart_seq_pkg::TX_STOP1 && !q.mode.tx_stop2 && q.tx_cnt == '0)
      |=> (q.irq_stat.tx && q.tx_st == uart_seq_pkg::TX_IDLE))
    else $error("completion interrupt missing after last stop bit");
  AST_TX_BUSY_IGNORED: assert property ( // RQ3
    (wr_fire && is_reg(q.aw_addr, uart_seq_pkg::OFS_TX) && tx_on &&
     q.tx_st != uart_seq_pkg::TX_IDLE && q.tx_cnt != '0)
      |=> ($stable(q.tx_st) && $stable(q.tx_data)))
    else $error("byte accepted while transmitter busy");
  AST_ERR_CLEAR: assert property ( // RQ4
    err_stat_read ##[2:8] buf_read |=> q.rx_err == '0)
    else $error("error flags not cleared by status then buffer read");
  AST_ERR_HOLD: assert property ( // RQ4
    (q.rx_err != '0 && !(rd_fire && q.err_armed)) |=> q.rx_err != '0)
    else $error("error flags cleared without read sequence");
  AST_OVERRUN: assert property ( // RQ5
    (rx_done_ev && q.rx_err != '0 && !rd_fire) |=> (q.rx_err.overrun && q.irq_stat.err))
    else $error("overrun not flagged with error pending");
  AST_DISCARD: assert property ( // RQ13
    (rx_done_ev && q.rx_full && !rd_fire) |=> ($stable(q.rx_buf) && q.rx_err.overrun))
    else $error("receive buffer overwritten on overrun");
  AST_ONE_STOP: assert property ( // RQ6
    (rx_done_ev) |=> q.rx_st == uart_seq_pkg::RX_IDLE)
    else $error("receiver waited beyond first stop bit");
  AST_IDLE_LEVEL: assert property ( // RQ7
    (q.tx_st == uart_seq_pkg::TX_IDLE) |-> q.serial_out == ~q.mode.tx_inv)
    else $error("idle line level wrong for inversion setting");
  AST_START_LEVEL: assert property ( // RQ7
    (q.tx_st == uart_seq_pkg::TX_START) |-> q.serial_out == q.mode.tx_inv)
    else $error("start bit level wrong for inversion setting");
  AST_POWER_OFF: assert property ( // RQ1
    (!q.mode.power) |=> (q.tx_st == uart_seq_pkg::TX_IDLE && q.rx_st == uart_seq_pkg::RX_IDLE))
    else $error("engine active with power bit clear");
endmodule : uart_seq_ctrl
`default_nettype wire

// *** logic/uart_seq_pkg.sv ***
`default_nettype none
package uart_seq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_OP_MODE = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_TX = 8'h08;
  localparam logic [7:0] OFS_RXBUF = 8'h0c;
  localparam logic [7:0] OFS_RXERR = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // Reset values
  localparam logic [7:0] OP_MODE_RST = 8'h00;
  localparam logic [15:0] BAUD_DIV_RST = 16'h043d;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [31:0] TX_IDLE_WORD = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic power;
    logic tx_en;
    logic rx_en;
    logic tx_inv;
    logic tx_stop2;
    logic [2:0] rsvd;
  } op_mode_t;

  typedef struct packed {
    logic frame;
    logic overrun;
  } rx_err_t;

  typedef struct packed {
    logic err;
    logic rx;
    logic tx;
  } irq_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_STOP1 = 3'b011,
    TX_STOP2 = 3'b100
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
endpackage : uart_seq_pkg
`default_nettype wire

// *** sim/async_serial_ctrl_sequencing_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module async_serial_ctrl_sequencing_tb_top;
  localparam int DIV = 16;
  localparam int LIMIT = 20000;
  logic aclk = 1'b0;
  logic clk_run = 1'b1;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, serial_out_pin;
  wire logic serial_in_pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #4 aclk = clk_run ? ~aclk : aclk;

  uart_seq_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irq(irq));

  uart_peer #(.DIV(DIV)) peer (.aclk(aclk), .tx_line(serial_out_pin), .rx_line(serial_in_pin));

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
    check({29'h0, b_hs, r}, {29'h0, 1'b1, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    logic ar_hs, r_hs;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
    check({29'h0, r_hs, r}, {29'h0, 1'b1, er});
    check(d, exp);
  endtask : rd

  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      summarize();
    end
  end

  initial begin
    logic [7:0] got;
    logic ok, v;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check({31'h0, serial_out_pin}, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd(uart_seq_pkg::OFS_OP_MODE, 32'h0);
    rd(uart_seq_pkg::OFS_BAUD, {16'h0, uart_seq_pkg::BAUD_DIV_RST});
    rd(uart_seq_pkg::OFS_IRQ_MASK, 32'h0);
    rd(8'h1c, 32'h0, uart_seq_pkg::RESP_SLVERR);
    wr(8'h20, 32'h1, uart_seq_pkg::RESP_SLVERR);
    wr(uart_seq_pkg::OFS_BAUD, 32'h10);
    wr(uart_seq_pkg::OFS_OP_MODE, 32'h80);
    wr(uart_seq_pkg::OFS_OP_MODE, 32'he0);
    rd(uart_seq_pkg::OFS_OP_MODE, 32'he0);
    // Second byte offered while busy must not disturb the first
    fork
      peer.recv(1'b0, got, ok);
      begin
        wr(uart_seq_pkg::OFS_TX, 32'ha5);
        rd(uart_seq_pkg::OFS_TX, 32'h1);
        wr(uart_seq_pkg::OFS_TX, 32'h3c);
      end
    join
    check({23'h0, ok, got}, 32'h1a5);
    repeat (DIV) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    wr(uart_seq_pkg::OFS_IRQ_MASK, 32'h7);
    check({31'h0, irq}, 32'h1);
    rd(uart_seq_pkg::OFS_IRQ_STAT, 32'h1);
    rd(uart_seq_pkg::OFS_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    // Inverted transmit with two stop bits, plain receive
    wr(uart_seq_pkg::OFS_OP_MODE, 32'hf8);
    check({31'h0, serial_out_pin}, 32'h0);
    fork
      peer.recv(1'b1, got, ok);
      wr(uart_seq_pkg::OFS_TX, 32'h5a);
    join
    check({23'h0, ok, got}, 32'h15a);
    repeat (DIV) @(posedge aclk);
    rd(uart_seq_pkg::OFS_TX, 32'h1);
    peer.send(8'h33, 1'b1);
    rd(uart_seq_pkg::OFS_IRQ_STAT, 32'h3);
    rd(uart_seq_pkg::OFS_RXBUF, 32'h33);
    rd(uart_seq_pkg::OFS_RXERR, 32'h0);
    wr(uart_seq_pkg::OFS_OP_MODE, 32'he0);
    // Back-to-back frames with a single stop bit, first one unread
    peer.send(8'h11, 1'b1);
    peer.send(8'h22, 1'b1);
    rd(uart_seq_pkg::OFS_RXERR, 32'h1);
    rd(uart_seq_pkg::OFS_RXBUF, 32'h11);
    rd(uart_seq_pkg::OFS_RXERR, 32'h0);
    // Buffer read before status read leaves the flag
    peer.send(8'h44, 1'b0);
    rd(uart_seq_pkg::OFS_RXBUF, 32'h44);
    rd(uart_seq_pkg::OFS_RXERR, 32'h2);
    peer.send(8'h55, 1'b1);
    rd(uart_seq_pkg::OFS_RXERR, 32'h3);
    rd(uart_seq_pkg::OFS_RXBUF, 32'h44);
    rd(uart_seq_pkg::OFS_RXERR, 32'h0);
    // Stopped state ignores traffic
    wr(uart_seq_pkg::OFS_OP_MODE, 32'h80);
    wr(uart_seq_pkg::OFS_OP_MODE, 32'h0);
    wr(uart_seq_pkg::OFS_TX, 32'h77);
    rd(uart_seq_pkg::OFS_TX, 32'h0);
    check({31'h0, serial_out_pin}, 32'h1);
    peer.send(8'h66, 1'b1);
    rd(uart_seq_pkg::OFS_RXBUF, 32'h44);
    // Clock stopped mid-frame, then reinitialised
    wr(uart_seq_pkg::OFS_OP_MODE, 32'h80);
    wr(uart_seq_pkg::OFS_OP_MODE, 32'hc0);
    wr(uart_seq_pkg::OFS_TX, 32'h0);
    repeat (3 * DIV) @(posedge aclk);
    v = serial_out_pin;
    check({31'h0, v}, 32'h0);
    clk_run = 1'b0;
    #3000;
    check({31'h0, serial_out_pin}, {31'h0, v});
    clk_run = 1'b1;
    @(posedge aclk);
    wr(uart_seq_pkg::OFS_OP_MODE, 32'h0);
    check({31'h0, serial_out_pin}, 32'h1);
    rd(uart_seq_pkg::OFS_TX, 32'h0);
    summarize();
  end
endmodule : async_serial_ctrl_sequencing_tb_top
`default_nettype wire

// *** sim/uart_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_peer #(
  parameter int DIV = 16
) (
  input wire logic aclk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;

  // Start, eight data bits LSB first, one stop bit
  task automatic send(input logic [7:0] b, input logic stop_ok);
    logic [9:0] f;
    f = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (DIV) @(posedge aclk);
    end
    if (!stop_ok) begin
      rx_line <= 1'b1;
      @(posedge aclk);
    end
  endtask : send

  // Accepts either polarity of the device's output
  task automatic recv(input logic inv, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while ((tx_line ^ inv) !== 1'b0 && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    repeat (DIV / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge aclk);
      b[i] = tx_line ^ inv;
    end
    repeat (DIV) @(posedge aclk);
    ok = (n < 4000) && ((tx_line ^ inv) === 1'b1);
  endtask : recv
endmodule : uart_peer
`default_nettype wire
